// >>> oscw_pkg.sv
package oscw_pkg;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_OSC2 = 8'h00;
  localparam logic [7:0] ADDR_OSC1 = 8'h04;
  localparam logic [7:0] ADDR_WDT_RESTART = 8'h08;
  localparam logic [7:0] ADDR_WDT_FREQ = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_WDT_COUNT = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int OSC2_NODIV_BIT = 0;
  localparam int OSC2_EXTMAIN_BIT = 1;
  localparam int OSC2_EXTSUB_BIT = 2;
  localparam int OSC2_VARIANT_BIT = 3;
  localparam int OSC2_FIXED0_BIT = 4;
  localparam int OSC2_PSRST_BIT = 7;
  localparam int OSC1_WAITSTOP_BIT = 5;
  localparam int FREQ_SEL_BIT = 0;
  localparam int FREQ_PAIRED_BIT = 8;
  localparam int STAT_WAIT_BIT = 0;
  localparam int STAT_STOP_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;

  // ****************************************************************
  // reset values and prescaler taps
  // ****************************************************************
  localparam logic RST_BIT_ZERO = 1'b0;
  localparam int TAP32_MSB = 4;
  localparam int TAP512_MSB = 8;

  // ****************************************************************
  // bus encodings
  // ****************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    OSCW_RUN,
    OSCW_WAIT,
    OSCW_STOP
  } oscw_mode_t;

  typedef struct packed {
    logic fixed0;
    logic variant;
    logic ext_sub;
    logic ext_main;
    logic no_div;
  } oscw_osc2_t;

  typedef struct packed {
    logic main_osc_en;
    logic sub_osc_en;
    logic sub_pin_gpio;
    logic cpu_clk_en;
    logic stop_exit_wdt_main;
    logic stop_exit_wdt_sub;
  } oscw_clk_out_t;

endpackage : oscw_pkg

// >>> oscw_prescaler.sv
`timescale 1ns/10ps
module oscw_prescaler #(
  parameter int WIDTH = 9
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic run, // prescaler clocks running
  input wire logic clear, // one-cycle prescaler initialise
  output logic div32_clock, // divide-by-32 tick
  output logic div512_clock // divide-by-512 tick
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // free counter, cleared by software
  assign cnt_d = clear ? '0 : (run ? cnt_q + 1'b1 : cnt_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  // taps fire on the last count of each period
  assign div32_clock = run & ~clear & (&cnt_q[oscw_pkg::TAP32_MSB:0]);
  assign div512_clock = run & ~clear & (&cnt_q[oscw_pkg::TAP512_MSB:0]);

endmodule : oscw_prescaler

// >>> oscw_wdt.sv
`timescale 1ns/10ps
module oscw_wdt #(
  parameter int CW = 15
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic freq_sel, // 1 selects divide-by-512 source
  input wire logic div32_clock, // divide-by-32 tick
  input wire logic div512_clock, // divide-by-512 tick
  input wire logic hold_req, // synchronised hold request
  input wire logic halt, // stop or wait halt
  input wire logic restart, // reload pulse
  output logic [CW-1:0] count, // current count
  output logic underflow // one-cycle underflow pulse
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic uf_q;
  logic src;
  logic count_en;

  // gated source; a short hold glitch can pass one count
  assign src = freq_sel ? div512_clock : div32_clock;
  assign count_en = ~hold_req & src & ~halt;

  // down counter, reload on restart or underflow
  assign cnt_d = restart ? '1 :
                 (count_en ? ((cnt_q == '0) ? '1 : cnt_q - 1'b1) : cnt_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '1;
      uf_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      uf_q <= count_en & ~restart & (cnt_q == '0);
    end
  end

  assign count = cnt_q;
  assign underflow = uf_q;

endmodule : oscw_wdt

// >>> oscw_top.sv
`timescale 1ns/10ps
module oscw_top #(
  parameter int WDT_W = 15, // watchdog counter width
  parameter int PRE_W = 9, // prescaler width
  parameter logic PROM_VARIANT = 1'b0, // 1 for programmable-rom parts
  parameter logic STOP_ENABLED = 1'b1 // 0 when the stop instruction is ordered off
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic [1:0] hresp, // response
  input wire logic data_length_flag, // cpu m flag, 0 pairs writes
  input wire logic stop_instruction, // stop executed pulse
  input wire logic wait_instruction, // wait executed pulse
  input wire logic wake_request, // interrupt request ends a mode
  input wire logic hold_pin_n, // hold pin, active low, async
  output oscw_pkg::oscw_clk_out_t clk_out, // clock controls
  output logic stop_mode, // in stop mode
  output logic wait_mode, // in wait mode
  output logic hold_state, // hold seen
  output logic wdt_underflow, // watchdog underflow pulse
  output logic [WDT_W-1:0] wdt_count // watchdog count
);

  // ****************************************************************
  // bus address phase
  // ****************************************************************
  logic ap_valid;
  logic dp_wr_q;
  logic [7:0] dp_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // a transfer is taken when selected, active and ready
  assign ap_valid = hsel & hready & (htrans == oscw_pkg::HTRANS_NONSEQ |
                                     htrans == oscw_pkg::HTRANS_SEQ);

  // capture write address for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (ce) begin
      dp_wr_q <= ap_valid & hwrite;
      dp_addr_q <= haddr;
    end
  end

  // no wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = oscw_pkg::HRESP_OKAY;

  // ****************************************************************
  // write decode
  // ****************************************************************
  logic wr_osc2;
  logic wr_osc1;
  logic wr_restart;
  logic wr_freq;
  logic paired_freq;
  logic ps_clear;

  assign wr_osc2 = dp_wr_q & (dp_addr_q == oscw_pkg::ADDR_OSC2);
  assign wr_osc1 = dp_wr_q & (dp_addr_q == oscw_pkg::ADDR_OSC1);
  assign wr_restart = dp_wr_q & (dp_addr_q == oscw_pkg::ADDR_WDT_RESTART);
  assign wr_freq = dp_wr_q & (dp_addr_q == oscw_pkg::ADDR_WDT_FREQ);
  // restart with m=0 also covers the following byte
  assign paired_freq = wr_restart & ~data_length_flag;
  // write-only initialise strobe
  assign ps_clear = wr_osc2 & hwdata[oscw_pkg::OSC2_PSRST_BIT];

  // ****************************************************************
  // control registers
  // ****************************************************************
  oscw_pkg::oscw_osc2_t osc2_q;
  oscw_pkg::oscw_osc2_t osc2_d;
  logic waitstop_q;
  logic freq_q;
  logic freq_d;

  // next values of the second control register
  always_comb begin
    osc2_d = osc2_q;
    if (wr_osc2) begin
      osc2_d.no_div = hwdata[oscw_pkg::OSC2_NODIV_BIT];
      osc2_d.ext_main = hwdata[oscw_pkg::OSC2_EXTMAIN_BIT];
      osc2_d.ext_sub = hwdata[oscw_pkg::OSC2_EXTSUB_BIT];
      osc2_d.variant = hwdata[oscw_pkg::OSC2_VARIANT_BIT];
      osc2_d.fixed0 = hwdata[oscw_pkg::OSC2_FIXED0_BIT];
    end
  end

  // frequency flag by direct or paired write
  assign freq_d = paired_freq ? hwdata[oscw_pkg::FREQ_PAIRED_BIT] :
                  (wr_freq ? hwdata[oscw_pkg::FREQ_SEL_BIT] : freq_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc2_q <= {oscw_pkg::RST_BIT_ZERO, PROM_VARIANT, 3'h0};
      waitstop_q <= oscw_pkg::RST_BIT_ZERO;
      freq_q <= oscw_pkg::RST_BIT_ZERO;
    end else if (ce) begin
      osc2_q <= osc2_d;
      waitstop_q <= wr_osc1 ? hwdata[oscw_pkg::OSC1_WAITSTOP_BIT] : waitstop_q;
      freq_q <= freq_d;
    end
  end

  // ****************************************************************
  // hold pin synchroniser
  // ****************************************************************
  logic hold_s1_q;
  logic hold_s2_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_s1_q <= 1'b0;
      hold_s2_q <= 1'b0;
    end else if (ce) begin
      hold_s1_q <= ~hold_pin_n;
      hold_s2_q <= hold_s1_q;
    end
  end

  assign hold_state = hold_s2_q;

  // ****************************************************************
  // stop and wait modes
  // ****************************************************************
  oscw_pkg::oscw_mode_t mode_q;
  oscw_pkg::oscw_mode_t mode_d;

  // instructions enter, interrupt requests leave
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      oscw_pkg::OSCW_RUN: begin
        if (stop_instruction & STOP_ENABLED) begin
          mode_d = oscw_pkg::OSCW_STOP;
        end else if (wait_instruction) begin
          mode_d = oscw_pkg::OSCW_WAIT;
        end
      end
      oscw_pkg::OSCW_WAIT: begin
        if (wake_request) begin
          mode_d = oscw_pkg::OSCW_RUN;
        end
      end
      oscw_pkg::OSCW_STOP: begin
        if (wake_request) begin
          mode_d = oscw_pkg::OSCW_RUN;
        end
      end
      default: begin
        mode_d = oscw_pkg::OSCW_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= oscw_pkg::OSCW_RUN;
    end else if (ce) begin
      mode_q <= mode_d;
    end
  end

  assign stop_mode = (mode_q == oscw_pkg::OSCW_STOP);
  assign wait_mode = (mode_q == oscw_pkg::OSCW_WAIT);

  // ****************************************************************
  // clock controls
  // ****************************************************************
  logic div2_phase_q;
  logic pre_run;
  logic wdt_halt;

  // divide-by-two phase of the main clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div2_phase_q <= 1'b0;
    end else if (ce) begin
      div2_phase_q <= ~div2_phase_q;
    end
  end

  // prescaler stops in stop, and in wait when asked
  assign pre_run = ~stop_mode & ~(wait_mode & waitstop_q);
  // watchdog halts in stop and in wait with bit 5 set
  assign wdt_halt = stop_mode | (wait_mode & waitstop_q);

  assign clk_out.cpu_clk_en = (mode_q == oscw_pkg::OSCW_RUN) &
                              (osc2_q.no_div | div2_phase_q);
  assign clk_out.main_osc_en = ~stop_mode & ~osc2_q.ext_main;
  assign clk_out.sub_osc_en = ~stop_mode & ~osc2_q.ext_sub;
  assign clk_out.sub_pin_gpio = osc2_q.ext_sub;
  assign clk_out.stop_exit_wdt_main = ~osc2_q.ext_main;
  assign clk_out.stop_exit_wdt_sub = ~osc2_q.ext_sub;

  // ****************************************************************
  // prescaler and watchdog
  // ****************************************************************
  logic div32_clock;
  logic div512_clock;

  oscw_prescaler #(
    .WIDTH(PRE_W)
  ) u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .run(pre_run),
    .clear(ps_clear),
    .div32_clock(div32_clock),
    .div512_clock(div512_clock)
  );

  oscw_wdt #(
    .CW(WDT_W)
  ) u_wdt (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .freq_sel(freq_q),
    .div32_clock(div32_clock),
    .div512_clock(div512_clock),
    .hold_req(hold_s2_q),
    .halt(wdt_halt),
    .restart(wr_restart),
    .count(wdt_count),
    .underflow(wdt_underflow)
  );

  // ****************************************************************
  // read mux, registered in the address phase
  // ****************************************************************
  logic [31:0] rd_osc2;
  logic [31:0] rd_osc1;
  logic [31:0] rd_freq;
  logic [31:0] rd_stat;
  logic [31:0] rd_cnt;

  // bit 7 write-only, bits 5 and 6 unimplemented read zero
  assign rd_osc2 = {27'h000_0000, osc2_q};
  assign rd_osc1 = {26'h000_0000, waitstop_q, 5'h00};
  assign rd_freq = {31'h0000_0000, freq_q};
  assign rd_stat = {29'h0000_0000, hold_s2_q, stop_mode, wait_mode};
  assign rd_cnt = {{(32 - WDT_W){1'b0}}, wdt_count};

  always_comb begin
    rdata_d = oscw_pkg::WORD_ZERO;
    case (haddr)
      oscw_pkg::ADDR_OSC2: rdata_d = rd_osc2;
      oscw_pkg::ADDR_OSC1: rdata_d = rd_osc1;
      oscw_pkg::ADDR_WDT_FREQ: rdata_d = rd_freq;
      oscw_pkg::ADDR_STATUS: rdata_d = rd_stat;
      oscw_pkg::ADDR_WDT_COUNT: rdata_d = rd_cnt;
      default: rdata_d = oscw_pkg::WORD_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= oscw_pkg::WORD_ZERO;
    end else if (ce & ap_valid & ~hwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;

endmodule : oscw_top

// >>> oscw_top_chk.sv
`timescale 1ns/10ps
module oscw_top_chk #(
  parameter int WDT_W = 15, // watchdog width
  parameter logic STOP_ENABLED = 1'b1 // stop instruction honoured
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic hsel, // slave select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // slave ready
  input wire logic [1:0] hresp, // response
  input wire logic stop_instruction, // stop pulse
  input wire logic wait_instruction, // wait pulse
  input wire logic wake_request, // mode exit
  input oscw_pkg::oscw_clk_out_t clk_out, // clock controls
  input wire logic stop_mode, // in stop
  input wire logic wait_mode, // in wait
  input wire logic hold_state, // hold seen
  input wire logic wdt_underflow, // underflow pulse
  input wire logic [WDT_W-1:0] wdt_count // watchdog count
);
  // ****************************************************************
  // port relations
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // bus answers and read data
  a_bus_okay: assert property (hreadyout && hresp == oscw_pkg::HRESP_OKAY)
    else $error("bus answer not ready and okay");
  a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  // mode entry and exit
  a_stop_entry: assert property (
    STOP_ENABLED && ce && stop_instruction && !wake_request |=> stop_mode)
    else $error("stop instruction did not enter stop");
  a_wait_entry: assert property (
    ce && wait_instruction && !stop_instruction && !wake_request |=> wait_mode)
    else $error("wait instruction did not enter wait");
  a_wake_exit: assert property (
    ce && wake_request && !stop_instruction && !wait_instruction |=> !stop_mode && !wait_mode)
    else $error("wake did not return to run");
  // clocks halted by the modes
  a_stop_clocks: assert property (
    stop_mode |-> !clk_out.main_osc_en && !clk_out.sub_osc_en && !clk_out.cpu_clk_en)
    else $error("clocks running in stop");
  a_wait_clock: assert property (
    wait_mode |-> !clk_out.cpu_clk_en) else $error("cpu clock running in wait");
  // watchdog gating
  a_stop_freeze: assert property (
    stop_mode |=> $stable(wdt_count)) else $error("watchdog counted in stop");
  a_hold_freeze: assert property (
    hold_state ##1 hold_state |-> $stable(wdt_count)) else $error("watchdog counted in hold");
  a_count_step: assert property (
    $changed(wdt_count) && wdt_count != {WDT_W{1'b1}} |-> wdt_count == $past(wdt_count) - 1'b1)
    else $error("watchdog step not one");
  a_under_reload: assert property (wdt_underflow |-> wdt_count == {WDT_W{1'b1}})
    else $error("underflow without reload");

  // main scenarios reached
  c_stop: cover property ($rose(stop_mode));
  c_wait: cover property ($rose(wait_mode));
  c_hold: cover property ($rose(hold_state));
  c_under: cover property (wdt_underflow);
endmodule : oscw_top_chk

// >>> testbench.sv
`timescale 1ns/10ps
bind oscw_top oscw_top_chk #(.WDT_W(WDT_W), .STOP_ENABLED(STOP_ENABLED)) chk_u (.*);
module testbench;
  localparam int CW = 4;
  localparam logic [CW-1:0] ONES = 4'hF;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic dlf = 1'b1;
  logic ce = 1'b1;
  logic hold_n = 1'b1;
  logic [2:0] ev = 3'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic [1:0] hresp;
  logic hreadyout, stop_mode, wait_mode, hold_state, wdt_underflow, a;
  logic [CW-1:0] wdt_count;
  oscw_pkg::oscw_clk_out_t clk_out;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;

  // device under test, hready fed back from the one slave
  oscw_top #(.WDT_W(CW)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .data_length_flag(dlf),
    .stop_instruction(ev[0]), .wait_instruction(ev[1]), .wake_request(ev[2]),
    .hold_pin_n(hold_n), .clk_out(clk_out), .stop_mode(stop_mode), .wait_mode(wait_mode),
    .hold_state(hold_state), .wdt_underflow(wdt_underflow), .wdt_count(wdt_count)
  );

  // ****************************************************************
  // clock, timeout and helpers
  // ****************************************************************
  always #2.5 hclk = ~hclk; // steady main clock, no soft reset relied on

  // hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one single ahb-lite transfer, read data left in rd
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= wr;
    htrans <= oscw_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask : xfer

  task automatic step(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask : step

  // one-cycle pulse on stop, wait or wake
  task automatic pulse(input logic [2:0] e);
    @(posedge hclk);
    ev <= e;
    @(posedge hclk);
    ev <= 3'h0;
    #1;
  endtask : pulse

  // prescaler init then watchdog reload, next tick 32 cycles on
  task automatic fresh();
    xfer(1'b1, oscw_pkg::ADDR_OSC2, 32'h0000_0080);
    xfer(1'b1, oscw_pkg::ADDR_WDT_RESTART, 32'h0000_0000);
  endtask : fresh

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, oscw_pkg::ADDR_WDT_COUNT, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    xfer(1'b0, oscw_pkg::ADDR_OSC2, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    xfer(1'b0, oscw_pkg::ADDR_WDT_FREQ, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    xfer(1'b0, oscw_pkg::ADDR_OSC1, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    xfer(1'b0, 8'h18, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // external clocks, undivided main, write-only init bit
    xfer(1'b1, oscw_pkg::ADDR_OSC2, 32'h0000_008F);
    check(clk_out, 6'h0C);
    step(1);
    check(clk_out, 6'h0C);
    xfer(1'b0, oscw_pkg::ADDR_OSC2, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    xfer(1'b1, oscw_pkg::ADDR_OSC2, 32'h0000_0000);
    check(clk_out & 6'h3B, 6'h33);
    a = clk_out.cpu_clk_en;
    step(1);
    check(clk_out.cpu_clk_en, 1'(~a));
    // prescaler init timing and div32 source
    fresh();
    step(16);
    check(wdt_count, ONES);
    step(24);
    check(wdt_count, ONES - 4'h1);
    // paired write of the frequency flag
    @(posedge hclk) dlf <= 1'b0;
    xfer(1'b1, oscw_pkg::ADDR_WDT_RESTART, 32'h0000_0100);
    xfer(1'b0, oscw_pkg::ADDR_WDT_FREQ, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    @(posedge hclk) dlf <= 1'b1;
    fresh();
    step(40);
    check(wdt_count, ONES);
    xfer(1'b0, oscw_pkg::ADDR_WDT_FREQ, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    @(posedge hclk) dlf <= 1'b0;
    fresh();
    @(posedge hclk) dlf <= 1'b1;
    xfer(1'b0, oscw_pkg::ADDR_WDT_FREQ, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // hold freezes and resumes
    fresh();
    step(40);
    @(posedge hclk) hold_n <= 1'b0;
    step(100);
    check(wdt_count, ONES - 4'h1);
    xfer(1'b0, oscw_pkg::ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0004);
    @(posedge hclk) hold_n <= 1'b1;
    step(4);
    xfer(1'b1, oscw_pkg::ADDR_OSC2, 32'h0000_0080);
    step(40);
    check(wdt_count, ONES - 4'h2);
    // wait mode with and without watchdog halt
    xfer(1'b1, oscw_pkg::ADDR_OSC1, 32'h0000_0020);
    fresh();
    pulse(3'h2);
    check({wait_mode, clk_out.cpu_clk_en}, 2'h2);
    step(100);
    check(wdt_count, ONES);
    pulse(3'h4);
    check(wait_mode, 1'b0);
    xfer(1'b1, oscw_pkg::ADDR_OSC2, 32'h0000_0080);
    step(40);
    check(wdt_count, ONES - 4'h1);
    xfer(1'b1, oscw_pkg::ADDR_OSC1, 32'h0000_0000);
    fresh();
    pulse(3'h2);
    step(40);
    check(wdt_count, ONES - 4'h1);
    pulse(3'h4);
    // stop mode, stop wins over wait
    fresh();
    pulse(3'h3);
    check({stop_mode, wait_mode}, 2'h2);
    check(clk_out & 6'h34, 6'h00);
    step(100);
    check(wdt_count, ONES);
    pulse(3'h4);
    check(stop_mode, 1'b0);
    // short hold pulse between ticks lets the count pass
    fresh();
    step(10);
    @(posedge hclk) hold_n <= 1'b0;
    step(3);
    @(posedge hclk) hold_n <= 1'b1;
    step(20);
    check(wdt_count, ONES - 4'h1);
    // clock enable low freezes prescaler and watchdog
    fresh();
    step(20);
    @(posedge hclk) ce <= 1'b0;
    step(40);
    check(wdt_count, ONES);
    @(posedge hclk) ce <= 1'b1;
    step(20);
    check(wdt_count, ONES - 4'h1);
    // underflow reloads the count
    fresh();
    for (n = 0; n < 700 && wdt_underflow !== 1'b1; n++) begin
      step(1);
    end
    check(n < 700, 1'b1);
    check(wdt_count, ONES);
    report_and_stop();
  end
endmodule : testbench
